/* File: aop_port.sv */
// Converter output port: strap decoding, parallel bus and serial shifter
// Operation
// R01 - Half-swap high puts low byte on upper lane
// R02 - Code format low inverts result MSB
// R03 - Serial select enables serial, tristates unused bits
// R04 - Pins two and three become divider inputs serially
// R05 - Divider slows clock only in master read-after-convert
// R06 - Divider pins high impedance in other serial modes
// R07 - Pin four selects master or slave clock
// R08 - Master mode drives internal serial clock out; the code drives it only while chip select is low
// R09 - Slave mode follows external clock, gated by select
// R10 - Pin five sets frame sync polarity
// R11 - Frame polarity low means frame sync active high
// R12 - Pin six inverts serial clock in serial modes
// R13 - Pins zero and one always parallel result bits; in serial mode the code drives them but holds them low
// R14 - Read-during-convert shifts previous result during conversion
// R15 - Serial result shifted out MSB first
// R16 - Slave updates data on rising or falling edge
// R17 - Host keeps straps static between conversions
`timescale 1ns/1ps
`default_nettype none
module aop_port
    import aop_pkg::*;
#(
    parameter int WIDTH = RESULT_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic result_valid_i,
    output logic result_ready_o,
    input wire logic [RESULT_W-1:0] result_data_i,
    input wire logic converting_i,
    input wire logic half_swap_select_i,
    input wire logic code_format_select_i,
    input wire logic port_type_select_i,
    input wire logic chip_select_b_i,
    input wire logic [RESULT_W-1:0] data_bus_i,
    output logic [RESULT_W-1:0] data_bus_o,
    output logic [RESULT_W-1:0] data_bus_oe_o,
    input wire logic serial_clock_i,
    output logic serial_clock_o,
    output logic serial_clock_oe_o,
    output logic frame_sync_o,
    output logic frame_sync_oe_o
);
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic cs_b_prev;
    logic sclk_prev;
    aop_cfg_s cfg;
    logic fifo_valid;
    logic fifo_pop;
    logic [RESULT_W-1:0] fifo_data;
    logic [RESULT_W-1:0] par_word;
    logic [RESULT_W-1:0] shreg;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [HALF_CNT_W-1:0] half_cnt;
    logic [HALF_CNT_W-1:0] half_len;
    logic sclk_int;
    aop_state_e state;
    logic master_on;
    logic slave_on;
    logic par_pop;
    logic m_start;
    logic s_start;
    logic load;
    logic cs_fall;
    logic act_edge;
    logic half_done;

    // Apply the output code to a raw result
    function automatic logic [RESULT_W-1:0] fmt_word(input logic [RESULT_W-1:0] w,
                                                     input logic binary);
        fmt_word = {w[RESULT_W-1] ^ ~binary, w[RESULT_W-2:0]}; // R02
    endfunction : fmt_word

    // Half period of the internal serial clock in system cycles
    function automatic logic [HALF_CNT_W-1:0] half_period(input logic [1:0] sel,
                                                          input logic read_during_convert_select);
        logic [HALF_CNT_W-1:0] base;
        base = HALF_CNT_W'(SCLK_HALF_CYC);
        half_period = read_during_convert_select ? base : base << sel; // R05
    endfunction : half_period

    aop_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(result_valid_i),
        .in_ready_o(result_ready_o),
        .in_data_i(result_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    // Every pin input is asynchronous here, so all pass two flops first
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1 <= SY_RESET;
            sync2 <= SY_RESET;
        end else begin
            sync1 <= {serial_clock_i, chip_select_b_i, port_type_select_i,
                      code_format_select_i, half_swap_select_i,
                      data_bus_i[PIN_RDC:PIN_DIV_LO]}; // R04 R07 R10 R12
            sync2 <= sync1;
        end
    end

    // Edge history and the decoded configuration bundle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cs_b_prev <= 1'b1;
            sclk_prev <= 1'b0;
            cfg <= CFG_RESET;
        end else begin
            cs_b_prev <= sync2[SY_CS_B];
            sclk_prev <= sync2[SY_SCLK];
            cfg.port_serial <= sync2[SY_PORT_SER]; // R03
            cfg.half_swap <= sync2[SY_HALF_SWAP];
            cfg.code_binary <= sync2[SY_CODE_BIN];
            cfg.clk_ext <= sync2[SY_CLK_EXT]; // R07
            cfg.frame_inv <= sync2[SY_FRAME_INV]; // R10
            cfg.clk_inv <= sync2[SY_CLK_INV]; // R12
            cfg.read_during_convert_select <= sync2[SY_RDC];
            cfg.div_sel <= sync2[SY_DIV1:SY_DIV0]; // R04
        end
    end

    // Mode decode; straps are assumed static while a word is in flight
    assign master_on = cfg.port_serial && !cfg.clk_ext; // R17
    assign slave_on = cfg.port_serial && cfg.clk_ext;
    assign cs_fall = cs_b_prev && !sync2[SY_CS_B];
    assign act_edge = cfg.clk_inv ? (sclk_prev && !sync2[SY_SCLK])
                                  : (!sclk_prev && sync2[SY_SCLK]); // R16
    assign half_len = half_period(cfg.div_sel, cfg.read_during_convert_select);
    assign half_done = (half_cnt == half_len - 1'b1);

    // Master starts inside or after the conversion as the read mode asks
    assign m_start = master_on && !sync2[SY_CS_B] && fifo_valid && (state == ST_IDLE)
                     && (converting_i == cfg.read_during_convert_select); // R14
    assign s_start = slave_on && cs_fall && fifo_valid && (state == ST_IDLE); // R09
    assign load = m_start || s_start;
    assign par_pop = !cfg.port_serial && fifo_valid;
    // Serial drain waits for the shifter, so a slow host backs up the FIFO
    assign fifo_pop = par_pop || load;

    // Parallel result register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            par_word <= WORD_RESET;
        end else if (par_pop) begin
            par_word <= fmt_word(fifo_data, cfg.code_binary); // R02
        end
    end

    // Serial engine: master clock generation and slave edge following
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_IDLE;
            shreg <= WORD_RESET;
            bit_cnt <= '0;
            half_cnt <= '0;
            sclk_int <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (load) begin
                        shreg <= fmt_word(fifo_data, cfg.code_binary); // R15
                        bit_cnt <= '0;
                        half_cnt <= '0;
                        sclk_int <= 1'b0;
                        state <= m_start ? ST_MSHIFT : ST_SSHIFT;
                    end
                end
                ST_MSHIFT: begin
                    if (half_done) begin
                        half_cnt <= '0;
                        sclk_int <= !sclk_int; // R08
                        if (sclk_int) begin
                            if (bit_cnt == LAST_BIT) begin
                                state <= ST_IDLE;
                            end else begin
                                shreg <= {shreg[RESULT_W-2:0], 1'b0}; // R15
                                bit_cnt <= bit_cnt + 1'b1;
                            end
                        end
                    end else begin
                        half_cnt <= half_cnt + 1'b1; // R05
                    end
                end
                ST_SSHIFT: begin
                    // Losing chip select abandons the word
                    if (sync2[SY_CS_B]) begin
                        state <= ST_IDLE;
                    end else if (act_edge) begin
                        if (bit_cnt == LAST_BIT) begin
                            state <= ST_IDLE;
                        end else begin
                            shreg <= {shreg[RESULT_W-2:0], 1'b0}; // R16
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Data bus value: byte lanes in parallel, shifter MSB on the data pin in serial
    always_comb begin
        if (cfg.port_serial) begin
            data_bus_o = '0;
            data_bus_o[PIN_SERIAL_DATA_OUT] = shreg[RESULT_W-1]; // R15
        end else if (cfg.half_swap) begin
            data_bus_o = {par_word[BYTE_W-1:0], par_word[RESULT_W-1:BYTE_W]}; // R01
        end else begin
            data_bus_o = par_word; // R01
        end
    end

    // Data bus enables; configuration pins are never driven in serial mode
    always_comb begin
        if (cfg.port_serial) begin
            data_bus_oe_o = '0; // R03 R06
            data_bus_oe_o[PIN_SERIAL_DATA_OUT] = !sync2[SY_CS_B];
            data_bus_oe_o[1:0] = 2'h3; // R13
        end else begin
            data_bus_oe_o = '1; // R03
        end
    end

    // Serial clock pin: driven by the master, an input in slave mode
    assign serial_clock_o = sclk_int ^ cfg.clk_inv; // R12
    assign serial_clock_oe_o = master_on && !sync2[SY_CS_B]; // R08 R09
    // Frame sync marks the master shift window with the chosen polarity
    assign frame_sync_o = (state == ST_MSHIFT) ^ cfg.frame_inv; // R11
    assign frame_sync_oe_o = master_on && !sync2[SY_CS_B]; // R10

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_load;
        load && !cfg.port_serial == 1'b0;
    endsequence
    sequence s_slave_edge;
        state == ST_SSHIFT && !sync2[SY_CS_B] && act_edge && bit_cnt != LAST_BIT;
    endsequence
    sequence s_master_go;
        state == ST_IDLE ##1 state == ST_MSHIFT;
    endsequence
    sequence s_last_half;
        state == ST_MSHIFT && half_done && sclk_int && bit_cnt == LAST_BIT;
    endsequence

    // Straps only move between frames, so $stable(cfg) just masks the settling cycles

    a_swap_lanes: assert property ( // R01
        par_pop && cfg.half_swap && $stable(cfg) |=>
        data_bus_o[RESULT_W-1:BYTE_W] == $past(fifo_data[BYTE_W-1:0]))
        else $error("low byte not on upper lane with half swap");
    a_code_msb: assert property ( // R02
        s_load |=> shreg[RESULT_W-1] == ($past(fifo_data[RESULT_W-1]) ^ !$past(cfg.code_binary)))
        else $error("serial MSB does not follow code format");
    a_serial_hiz: assert property ( // R03
        cfg.port_serial |-> data_bus_oe_o[RESULT_W-1:PIN_SERIAL_DATA_OUT+1] == '0
                            && data_bus_oe_o[PIN_RDC:PIN_DIV_LO] == '0)
        else $error("unused data pins driven in serial mode");
    a_div_pins_hiz: assert property ( // R06
        cfg.port_serial && !(master_on && !cfg.read_during_convert_select) |-> data_bus_oe_o[3:2] == 2'h0)
        else $error("divider pins driven outside master read after convert");
    a_fast_clock: assert property ( // R05
        state == ST_MSHIFT && cfg.read_during_convert_select && $stable(cfg) && $rose(sclk_int)
        |=> $fell(sclk_int))
        else $error("read during convert clock is divided");
    a_master_drive: assert property ( // R08
        master_on && !sync2[SY_CS_B] |-> serial_clock_oe_o && !data_bus_oe_o[PIN_DIV_LO])
        else $error("master clock not driven");
    a_frame_level: assert property ( // R11
        state == ST_MSHIFT |-> frame_sync_o == !cfg.frame_inv)
        else $error("frame sync polarity wrong");
    a_low_bits: assert property ( // R13
        !cfg.port_serial |-> data_bus_oe_o[1:0] == 2'h3)
        else $error("bits zero and one not driven in parallel mode");
    a_read_window: assert property ( // R14
        s_master_go |-> $past(converting_i) == $past(cfg.read_during_convert_select))
        else $error("master read outside its window");
    a_slave_shift: assert property ( // R16
        s_slave_edge |=> shreg == {$past(shreg[RESULT_W-2:0]), 1'b0})
        else $error("slave shifter did not move on active edge");
    a_slave_ext: assert property ( // R09
        slave_on |-> !serial_clock_oe_o)
        else $error("serial clock driven in slave mode");
    a_slow_clock: assert property ( // R05
        state == ST_MSHIFT && !cfg.read_during_convert_select && cfg.div_sel == 2'h1 && $stable(cfg)
        && $rose(sclk_int) |=> !$fell(sclk_int))
        else $error("read after convert clock not divided");
    a_master_end: assert property ( // R15
        s_last_half |=> state == ST_IDLE && !sclk_int)
        else $error("master frame did not end after sixteen bits");
endmodule : aop_port
`default_nettype wire

/* File: aop_pkg.sv */
// Package: constants and carrier types for the converter output port block
package aop_pkg;
    // Result word
    localparam int RESULT_W = 16;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;

    // Clock and serial timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCLK_BASE_PERIOD_NS = 8;
    // Half period of the fastest internal serial clock, rounded up, never below one cycle
    localparam int SCLK_HALF_RAW = (SCLK_BASE_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW;
    localparam int HALF_CNT_W = 5;
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hF;

    // Positions in the synchronised pin vector
    localparam int SY_DIV0 = 0;
    localparam int SY_DIV1 = 1;
    localparam int SY_CLK_EXT = 2;
    localparam int SY_FRAME_INV = 3;
    localparam int SY_CLK_INV = 4;
    localparam int SY_RDC = 5;
    localparam int SY_HALF_SWAP = 6;
    localparam int SY_CODE_BIN = 7;
    localparam int SY_PORT_SER = 8;
    localparam int SY_CS_B = 9;
    localparam int SY_SCLK = 10;
    localparam int SY_W = 11;
    // Idle level of the synchronisers: chip select deasserted, rest low
    localparam logic [SY_W-1:0] SY_RESET = 11'h200;

    // Data-bus pin positions that change role in serial mode
    localparam int PIN_DIV_LO = 2;
    localparam int PIN_CLK_EXT = 4;
    localparam int PIN_FRAME_INV = 5;
    localparam int PIN_CLK_INV = 6;
    localparam int PIN_RDC = 7;
    localparam int PIN_SERIAL_DATA_OUT = 8;

    // Reset values
    localparam logic [RESULT_W-1:0] WORD_RESET = 16'h0000;

    // Static configuration carried as one bundle
    typedef struct packed {
        logic port_serial;
        logic half_swap;
        logic code_binary;
        logic clk_ext;
        logic frame_inv;
        logic clk_inv;
        logic read_during_convert_select;
        logic [1:0] div_sel;
    } aop_cfg_s;

    localparam aop_cfg_s CFG_RESET = '0;

    // Serial engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MSHIFT = 2'b01,
        ST_SSHIFT = 2'b10
    } aop_state_e;
endpackage : aop_pkg

/* File: aop_fifo.sv */
// Result FIFO between the conversion engine and the output port
`timescale 1ns/1ps
`default_nettype none
module aop_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count
    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr];

    // Storage has no reset; only the pointers and the count are reset
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : aop_fifo
`default_nettype wire

/* File: aop_host.sv */
// Host-side model that reads serial frames from the converter output port
`timescale 1ns/1ps
`default_nettype none
module aop_host (
    input wire logic clk_i,
    input wire logic slave_i,
    input wire logic clk_inv_i,
    input wire logic frame_inv_i,
    input wire logic sclk_in_i,
    input wire logic frame_i,
    input wire logic sdo_i,
    output logic sclk_o,
    output logic [15:0] word_o,
    output logic [15:0] cycles_o,
    output logic [7:0] frames_o,
    output logic [15:0] slave_word_o
);
    logic act;
    logic prev_act = 1'b0;
    logic prev_sclk = 1'b0;
    // Frame is active when the sync level differs from its idle level
    assign act = !slave_i && (frame_i ^ frame_inv_i);
    initial word_o = 16'h0000;
    initial cycles_o = 16'h0000;
    initial frames_o = 8'h00;
    initial sclk_o = 1'b0;
    initial slave_word_o = 16'h0000;
    // Master frames: sample on the internal rising edge, data moves on the falling one
    always @(posedge clk_i) begin
        prev_act <= act;
        prev_sclk <= sclk_in_i ^ clk_inv_i;
        if (act) begin
            cycles_o <= prev_act ? cycles_o + 16'h0001 : 16'h0001;
        end
        if (act && !prev_sclk && (sclk_in_i ^ clk_inv_i)) begin
            word_o <= {word_o[14:0], sdo_i};
        end
        if (!act && prev_act) begin
            frames_o <= frames_o + 8'h01;
        end
    end
    // Slave frame: the clock runs only inside the frame and rests at its idle level
    task automatic read_slave(input logic inv);
        sclk_o = inv;
        for (int i = 0; i < 16; i++) begin
            #32;
            slave_word_o = {slave_word_o[14:0], sdo_i};
            sclk_o = !inv;
            #32;
            sclk_o = inv;
        end
    endtask : read_slave
endmodule : aop_host
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the converter output port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import aop_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic valid = 1'b0;
    logic [15:0] data = 16'h0000;
    logic converting = 1'b0;
    logic swap = 1'b0;
    logic fmt = 1'b1;
    logic ser = 1'b0;
    logic cs_b = 1'b1;
    logic [1:0] div = 2'b00;
    logic ext = 1'b0;
    logic finv = 1'b0;
    logic cinv = 1'b0;
    logic read_during_convert_select = 1'b0;
    logic ready, sclk_o, sclk_oe, fs, fs_oe, h_sclk;
    logic [15:0] bus_o, bus_oe, bus_i, h_word, h_cyc, h_sword;
    logic [7:0] h_frames;
    int n_errors = 0;
    int samples_checked = 0;
    // Configuration pins are read only where the port does not drive them
    assign bus_i = {8'h00, read_during_convert_select, cinv, finv, ext, div, 2'b00};
    always #2 clk_i = ~clk_i;
    aop_port uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .result_valid_i(valid),
        .result_ready_o(ready), .result_data_i(data), .converting_i(converting),
        .half_swap_select_i(swap), .code_format_select_i(fmt),
        .port_type_select_i(ser), .chip_select_b_i(cs_b), .data_bus_i(bus_i),
        .data_bus_o(bus_o), .data_bus_oe_o(bus_oe), .serial_clock_i(h_sclk),
        .serial_clock_o(sclk_o), .serial_clock_oe_o(sclk_oe), .frame_sync_o(fs),
        .frame_sync_oe_o(fs_oe));
    aop_host u_host (.clk_i(clk_i), .slave_i(ext), .clk_inv_i(cinv), .frame_inv_i(finv),
        .sclk_in_i(sclk_o), .frame_i(fs), .sdo_i(bus_o[PIN_SERIAL_DATA_OUT]), .sclk_o(h_sclk),
        .word_o(h_word), .cycles_o(h_cyc), .frames_o(h_frames), .slave_word_o(h_sword));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("errors %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    // Inputs move one nanosecond after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    // Hold the offer until an edge that sees ready high
    task automatic push(input logic [15:0] w);
        logic taken;
        valid = 1'b1;
        data = w;
        for (int i = 0; i < 100; i++) begin
            taken = ready;
            @(posedge clk_i);
            #1;
            if (taken) begin
                valid = 1'b0;
                // Let an edge pass so a following offer starts from a low valid
                step(1);
                return;
            end
        end
        n_errors++;
        complete_run();
    endtask : push
    function automatic logic [15:0] coded(input logic [15:0] raw);
        return fmt ? raw : raw ^ 16'h8000;
    endfunction : coded
    // One master frame with chip select low; the word is already queued
    task automatic master_frame(input logic [15:0] raw);
        logic [7:0] start_cnt;
        logic [15:0] half;
        start_cnt = h_frames;
        half = read_during_convert_select ? 16'h0001 : (16'h0001 << div);
        // Open the read window; only one queued word may go out
        converting = read_during_convert_select;
        cs_b = 1'b0;
        step(6);
        check(bus_oe, 16'h0103);
        check({14'h0000, fs_oe, sclk_oe}, 16'h0003);
        for (int i = 0; i < 1200 && fs != finv; i++) step(1);
        // Close the window before the engine can take the next queued word
        converting = !read_during_convert_select;
        step(2);
        if (h_frames == start_cnt) begin
            n_errors++;
            complete_run();
        end
        check(h_word, coded(raw));
        check({15'h0000, (h_cyc + 16'h0002 >= (half << 5)) && (h_cyc <= (half << 5) + 16'h0002)},
            16'h0001);
        check({15'h0000, fs}, {15'h0000, finv});
        check({15'h0000, sclk_o}, {15'h0000, cinv});
        cs_b = 1'b1;
        step(4);
    endtask : master_frame
    initial begin
        step(10);
        check(bus_oe, 16'hFFFF);
        check({15'h0000, ready}, 16'h0001);
        rst_b_i = 1'b1;
        step(2);
        // Parallel port: every lane order and code format
        for (int k = 0; k < 4; k++) begin
            swap = k[0];
            fmt = k[1];
            step(4);
            push(16'hA5C3 + 16'(k));
            step(4);
            check(bus_o, swap ? {coded(16'hA5C3 + 16'(k))} >> 8 | coded(16'hA5C3 + 16'(k)) << 8
                : coded(16'hA5C3 + 16'(k)));
            check(bus_oe, 16'hFFFF);
        end
        // Serial master: queue fills while the host holds chip select off
        ser = 1'b1;
        step(4);
        for (int i = 0; i < 16; i++) push(16'h1230 + 16'(i * 16'h0111));
        check({15'h0000, ready}, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            div = i[1:0];
            finv = i[2];
            cinv = i[3];
            fmt = i[0] ^ i[3];
            step(4);
            master_frame(16'h1230 + 16'(i * 16'h0111));
        end
        check({15'h0000, ready}, 16'h0001);
        // Read during conversion ignores the divider setting
        read_during_convert_select = 1'b1;
        converting = 1'b1;
        div = 2'b11;
        step(4);
        push(16'h7E81);
        master_frame(16'h7E81);
        read_during_convert_select = 1'b0;
        converting = 1'b0;
        // Slave mode with both clock senses
        ext = 1'b1;
        for (int k = 0; k < 2; k++) begin
            cinv = k[0];
            step(4);
            push(16'hC00D ^ 16'(k * 16'h3333));
            cs_b = 1'b0;
            step(6);
            check(bus_oe, 16'h0103);
            check({14'h0000, fs_oe, sclk_oe}, 16'h0000);
            u_host.read_slave(cinv);
            step(8);
            check(h_sword, coded(16'hC00D ^ 16'(k * 16'h3333)));
            cs_b = 1'b1;
            step(4);
        end
        complete_run();
    end
endmodule : testbench
`default_nettype wire
